// ==== hdl/stur_cfg.svh ====
// Constants for the self-test and UTC offset report framer
`ifndef STUR_CFG_SVH
`define STUR_CFG_SVH
// Timing: self-test period and system clock rate
`define STUR_BIT_PERIOD_MS 1000
`define STUR_CLK_HZ        10000000
`define STUR_MS_PER_S      1000
// Output FIFO shape: one port flag plus one byte, eight entries
`define STUR_FIFO_WIDTH    9
`define STUR_FIFO_DEPTH    8
// Acceptable parameter-memory checksums (values are arbitrary)
`define STUR_NV_OK0        16'h5A5A
`define STUR_NV_OK1        16'hA5A5
`define STUR_NV_OK2        16'h1234
`define STUR_NV_OK3        16'hFEDC
// Commanded fractional offset range, units of 0.0001 us
`define STUR_OFS_MAX       32'sh004C4B40
`define STUR_OFS_MIN       (-32'sh004C4B40)
// Integer-hour part of the inter-system offset
`define STUR_OFS_HOURS     8'h03
// Reference-time scaling and field limits
`define STUR_TOT_SHIFT     12
`define STUR_WEEK_MASK     16'h03FF
`define STUR_DAY_MIN       16'h0001
`define STUR_DAY_MAX       16'h0007
// Sentence characters
`define STUR_CH_P          8'h50
`define STUR_CH_F          8'h46
`define STUR_CH_COMMA      8'h2C
`define STUR_CH_STAR       8'h2A
`define STUR_CH_CR         8'h0D
`define STUR_CH_LF         8'h0A
`define STUR_CH_ZERO       8'h30
`define STUR_CH_HEXA       8'h37
`define STUR_NIB_TEN       4'hA
// Sentence headers: common prefix and per-sentence tag with comma
`define STUR_HDR_PFX       56'h2450415348522C
`define STUR_TAG_TEST      32'h4249542C
`define STUR_TAG_UTC       32'h4455472C
`define STUR_HDR_BYTES     10
// Byte positions inside the sentences
`define STUR_HDR_LEN       5'h0B
`define STUR_POS_C1        5'h0B
`define STUR_POS_C2        5'h0D
`define STUR_POS_C3        5'h0F
`define STUR_POS_STAR      5'h10
`define STUR_POS_HI        5'h11
`define STUR_POS_LO        5'h12
`define STUR_POS_CR        5'h13
`define STUR_TEST_LAST     5'h14
`define STUR_UTC_CR        5'h19
`define STUR_UTC_LAST      5'h1A
`endif

// ==== hdl/stur_pkg.sv ====
// Types for the self-test and UTC offset report framer
package stur_pkg;
	typedef enum logic [1:0] {
		STUR_PORT_NONE = 2'h0,
		STUR_PORT_A    = 2'h1,
		STUR_PORT_B    = 2'h2
	} stur_port_t;
	typedef enum logic [1:0] {
		STUR_FR_IDLE = 2'h0,
		STUR_FR_TEST = 2'h1,
		STUR_FR_UTC  = 2'h2
	} stur_state_t;
	typedef struct packed {
		logic       portB;
		logic [7:0] data;
	} stur_tx_t;
	typedef struct packed {
		logic [31:0] refTimeSec;
		logic [15:0] refWeek;
		logic [15:0] curLeap;
		logic [15:0] changeWeek;
		logic [15:0] changeDay;
		logic [15:0] newLeap;
	} stur_iono_t;
	typedef struct packed {
		logic [7:0]         hours;
		logic [15:0]        leapSec;
		logic signed [31:0] frac;
	} stur_offset_t;
endpackage

// ==== hdl/stur_top.sv ====
// Self-test status sentence and UTC offset reply framer with output FIFO
`timescale 1ns/1ps
`include "stur_cfg.svh"

// Byte FIFO with a registered output stage
module stur_fifo #(
	parameter int WIDTH = `STUR_FIFO_WIDTH,
	parameter int DEPTH = `STUR_FIFO_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid_r,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData_r
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// Full and empty come straight from the occupancy count
	assign inReady = count_r != (AW+1)'(DEPTH);
	assign push    = inValid && inReady;
	assign pop     = (count_r != '0) && (!outValid_r || outReady);

	// Storage array has no reset
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	// Pointers, count and output stage
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wrPtr_r    <= '0;
			rdPtr_r    <= '0;
			count_r    <= '0;
			outValid_r <= 1'b0;
			outData_r  <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r   <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
				outData_r <= mem[rdPtr_r];
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
			if (pop) begin
				outValid_r <= 1'b1;
			end else if (outReady) begin
				outValid_r <= 1'b0;
			end
		end
	end
endmodule

// Self-test, offset command and report framer
module stur_top #(
	parameter int unsigned BIT_PERIOD_CYC = 32'((64'(`STUR_BIT_PERIOD_MS)
		* 64'(`STUR_CLK_HZ)) / 64'(`STUR_MS_PER_S))
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  batteryVoltageOk,
	input  wire logic [15:0]           nvParamSum,
	input  wire logic                  fatalResetFlag,
	input  wire logic                  fatalFault,
	input  wire logic                  selfTestQuery,
	input  wire stur_pkg::stur_port_t  selfTestPort,
	input  wire logic                  utcOffsetQuery,
	input  wire stur_pkg::stur_port_t  utcPort,
	input  wire logic                  queryArrivalB,
	input  wire logic                  setOffsetStrobe,
	input  wire logic signed [31:0]    setOffsetValue,
	input  wire logic                  offsetSourceSelect,
	input  wire logic signed [31:0]    computedOffsetFrac,
	input  wire stur_pkg::stur_iono_t  ionoRecord,
	input  wire logic                  txReady,
	output logic                       txValid_r,
	output stur_pkg::stur_tx_t         txItem_r,
	output logic                       resultBattery_r,
	output logic                       resultParams_r,
	output logic                       resultFatal_r,
	output logic                       testDone_r,
	output logic                       offsetAccepted_r,
	output logic                       offsetRejected_r,
	output stur_pkg::stur_offset_t     activeOffset_r,
	output logic                       framerBusy_r
);
	// Named port wins, otherwise the port the query came in on
	function automatic logic resolvePortB(stur_pkg::stur_port_t p,
		logic arrB);
		return (p == stur_pkg::STUR_PORT_NONE) ? arrB
			: (p == stur_pkg::STUR_PORT_B);
	endfunction

	// Parameter checksum must match one acceptable entry
	function automatic logic nvSumOk(logic [15:0] v);
		return (v == `STUR_NV_OK0) || (v == `STUR_NV_OK1)
			|| (v == `STUR_NV_OK2) || (v == `STUR_NV_OK3);
	endfunction

	// Nibble to uppercase hex character
	function automatic logic [7:0] hexChar(logic [3:0] n);
		return (n < `STUR_NIB_TEN) ? `STUR_CH_ZERO + 8'(n)
			: `STUR_CH_HEXA + 8'(n);
	endfunction

	// XOR of the header bytes that follow the dollar sign
	function automatic logic [7:0] hdrXor(logic [87:0] h);
		logic [7:0] x;
		x = '0;
		for (int i = 0; i < `STUR_HDR_BYTES; i++) begin
			x = x ^ h[i*8 +: 8];
		end
		return x;
	endfunction

	// Pass or fail character
	function automatic logic [7:0] pfChar(logic fail);
		return fail ? `STUR_CH_F : `STUR_CH_P;
	endfunction

	localparam logic [87:0] HDR_TEST = {`STUR_HDR_PFX, `STUR_TAG_TEST};
	localparam logic [87:0] HDR_UTC  = {`STUR_HDR_PFX, `STUR_TAG_UTC};

	logic [31:0]           periodCnt_r;
	logic                  startDone_r;
	logic                  periodHit;
	logic                  runTest;
	logic                  ofsInRange;
	logic signed [31:0]    cmdFrac_r;
	stur_pkg::stur_state_t state_r;
	stur_pkg::stur_state_t state_nxt;
	logic [4:0]            idx_r;
	logic                  bitPend_r;
	logic                  bitPortB_r;
	logic                  utcPend_r;
	logic                  utcPortB_r;
	logic                  curPortB_r;
	logic [2:0]            snapRes_r;
	logic [6:0][15:0]      words_r;
	logic [6:0][15:0]      wordsNxt;
	logic [15:0]           dayClamped;
	logic                  startTest;
	logic                  startUtc;
	logic                  fifoInValid;
	logic                  fifoInReady;
	logic                  lastByte;
	logic [7:0]            testCsum;
	logic [7:0]            testByte;
	logic [7:0]            utcByte;
	logic [4:0]            utcK;
	logic [15:0]           utcWord;
	stur_pkg::stur_tx_t    fifoIn;

	// Self-test scheduling: one run after reset, then every period
	assign periodHit = periodCnt_r == 32'(BIT_PERIOD_CYC - 1);
	assign runTest   = !startDone_r || periodHit;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			periodCnt_r <= '0;
			startDone_r <= 1'b0;
			testDone_r  <= 1'b0;
		end else begin
			periodCnt_r <= runTest ? '0 : periodCnt_r + 1'b1;
			startDone_r <= 1'b1;
			testDone_r  <= runTest;
		end
	end

	// Result fields, 1 means fail; straps are caught after release
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			resultBattery_r <= 1'b0;
			resultParams_r  <= 1'b0;
			resultFatal_r   <= 1'b0;
		end else begin
			if (runTest) begin
				resultBattery_r <= !batteryVoltageOk;
			end
			if (!startDone_r) begin
				resultParams_r <= !nvSumOk(nvParamSum);
				resultFatal_r  <= fatalResetFlag || fatalFault;
			end else if (fatalFault) begin
				resultFatal_r <= 1'b1;
			end
		end
	end

	// Offset command: range check and source selection
	assign ofsInRange = (setOffsetValue <= `STUR_OFS_MAX)
		&& (setOffsetValue >= `STUR_OFS_MIN);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cmdFrac_r        <= '0;
			offsetAccepted_r <= 1'b0;
			offsetRejected_r <= 1'b0;
			activeOffset_r   <= '0;
		end else begin
			offsetAccepted_r <= setOffsetStrobe && ofsInRange;
			offsetRejected_r <= setOffsetStrobe && !ofsInRange;
			if (setOffsetStrobe && ofsInRange) begin
				cmdFrac_r <= setOffsetValue;
			end
			activeOffset_r.hours   <= `STUR_OFS_HOURS;
			activeOffset_r.leapSec <= ionoRecord.curLeap;
			activeOffset_r.frac    <= offsetSourceSelect
				? cmdFrac_r : computedOffsetFrac;
		end
	end

	// Reply words built from the correction record
	assign dayClamped = (ionoRecord.changeDay < `STUR_DAY_MIN) ? `STUR_DAY_MIN
		: (ionoRecord.changeDay > `STUR_DAY_MAX) ? `STUR_DAY_MAX
		: ionoRecord.changeDay;
	assign wordsNxt[0] = ionoRecord.refWeek & `STUR_WEEK_MASK;
	assign wordsNxt[1] = 16'(ionoRecord.refTimeSec
		>> `STUR_TOT_SHIFT);
	assign wordsNxt[2] = ionoRecord.curLeap;
	assign wordsNxt[3] = ionoRecord.changeWeek & `STUR_WEEK_MASK;
	assign wordsNxt[4] = dayClamped;
	assign wordsNxt[5] = ionoRecord.newLeap;
	assign wordsNxt[6] = 16'(wordsNxt[0] + wordsNxt[1] + wordsNxt[2]
		+ wordsNxt[3] + wordsNxt[4] + wordsNxt[5]);

	// Framer control: start, advance and end of a sentence
	assign startTest   = (state_r == stur_pkg::STUR_FR_IDLE) && bitPend_r;
	assign startUtc    = (state_r == stur_pkg::STUR_FR_IDLE)
		&& !bitPend_r && utcPend_r;
	assign fifoInValid = state_r != stur_pkg::STUR_FR_IDLE;
	assign lastByte    = (state_r == stur_pkg::STUR_FR_TEST)
		? (idx_r == `STUR_TEST_LAST) : (idx_r == `STUR_UTC_LAST);

	// Next framer state: leave idle on a pending query, back after last byte
	always_comb begin
		case (state_r)
			stur_pkg::STUR_FR_IDLE:
				state_nxt = startTest ? stur_pkg::STUR_FR_TEST
					: startUtc ? stur_pkg::STUR_FR_UTC
					: stur_pkg::STUR_FR_IDLE;
			stur_pkg::STUR_FR_TEST, stur_pkg::STUR_FR_UTC:
				state_nxt = (fifoInReady && lastByte)
					? stur_pkg::STUR_FR_IDLE : state_r;
			default: state_nxt = stur_pkg::STUR_FR_IDLE;
		endcase
	end

	// Self-test sentence bytes
	assign testCsum = hdrXor(HDR_TEST) ^ pfChar(snapRes_r[2])
		^ `STUR_CH_COMMA ^ pfChar(snapRes_r[1]) ^ `STUR_CH_COMMA
		^ pfChar(snapRes_r[0]);
	assign testByte = (idx_r < `STUR_HDR_LEN)
		? HDR_TEST[8*(`STUR_HDR_BYTES - idx_r) +: 8]
		: (idx_r == `STUR_POS_C1)   ? pfChar(snapRes_r[2])
		: (idx_r == `STUR_POS_C2)   ? pfChar(snapRes_r[1])
		: (idx_r == `STUR_POS_C3)   ? pfChar(snapRes_r[0])
		: (idx_r == `STUR_POS_STAR) ? `STUR_CH_STAR
		: (idx_r == `STUR_POS_HI)   ? hexChar(testCsum[7:4])
		: (idx_r == `STUR_POS_LO)   ? hexChar(testCsum[3:0])
		: (idx_r == `STUR_POS_CR)   ? `STUR_CH_CR
		: (idx_r < `STUR_POS_C3)    ? `STUR_CH_COMMA
		: `STUR_CH_LF;

	// Reply bytes: header, then seven words low byte first
	assign utcK    = idx_r - `STUR_HDR_LEN;
	assign utcWord = words_r[utcK[3:1]];
	assign utcByte = (idx_r < `STUR_HDR_LEN)
		? HDR_UTC[8*(`STUR_HDR_BYTES - idx_r) +: 8]
		: (idx_r == `STUR_UTC_CR) ? `STUR_CH_CR
		: (idx_r == `STUR_UTC_LAST) ? `STUR_CH_LF
		: (utcK[0] ? utcWord[15:8] : utcWord[7:0]);

	assign fifoIn.portB = curPortB_r;
	assign fifoIn.data  = (state_r == stur_pkg::STUR_FR_UTC)
		? utcByte : testByte;

	// Pending queries; a new query in the start cycle is kept
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bitPend_r  <= 1'b0;
			bitPortB_r <= 1'b0;
			utcPend_r  <= 1'b0;
			utcPortB_r <= 1'b0;
		end else begin
			bitPend_r <= selfTestQuery || (bitPend_r && !startTest);
			utcPend_r <= utcOffsetQuery || (utcPend_r && !startUtc);
			if (selfTestQuery) begin
				bitPortB_r <= resolvePortB(selfTestPort, queryArrivalB);
			end
			if (utcOffsetQuery) begin
				utcPortB_r <= resolvePortB(utcPort, queryArrivalB);
			end
		end
	end

	// Framer state, byte index and snapshots taken at sentence start
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r      <= stur_pkg::STUR_FR_IDLE;
			idx_r        <= '0;
			curPortB_r   <= 1'b0;
			snapRes_r    <= '0;
			words_r      <= '0;
			framerBusy_r <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			framerBusy_r <= state_nxt != stur_pkg::STUR_FR_IDLE;
			if (startTest) begin
				idx_r      <= '0;
				curPortB_r <= bitPortB_r;
				snapRes_r  <= {resultBattery_r, resultParams_r, resultFatal_r};
			end else if (startUtc) begin
				idx_r      <= '0;
				curPortB_r <= utcPortB_r;
				words_r    <= wordsNxt;
			end else if (fifoInValid && fifoInReady) begin
				idx_r <= idx_r + 1'b1;
			end
		end
	end

	// Output buffer; a stalled consumer stalls the framer
	stur_fifo #(
		.WIDTH (`STUR_FIFO_WIDTH),
		.DEPTH (`STUR_FIFO_DEPTH)
	) u_fifo (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.inValid    (fifoInValid),
		.inReady    (fifoInReady),
		.inData     (fifoIn),
		.outValid_r (txValid_r),
		.outReady   (txReady),
		.outData_r  (txItem_r)
	);
endmodule

// ==== testbench/stur_sva.sv ====
// Port assertions for the report framer
`timescale 1ns/1ps
`include "stur_cfg.svh"
module stur_sva #(
	parameter int unsigned BIT_PERIOD_CYC = 32'h00989680
) (
	input wire logic                   sys_clk,
	input wire logic                   rst_n,
	input wire logic                   batteryVoltageOk,
	input wire logic                   setOffsetStrobe,
	input wire logic signed [31:0]     setOffsetValue,
	input wire logic                   offsetSourceSelect,
	input wire logic signed [31:0]     computedOffsetFrac,
	input wire logic                   txReady,
	input wire logic                   txValid_r,
	input wire stur_pkg::stur_tx_t     txItem_r,
	input wire logic                   resultBattery_r,
	input wire logic                   resultParams_r,
	input wire logic                   resultFatal_r,
	input wire logic                   testDone_r,
	input wire logic                   offsetAccepted_r,
	input wire logic                   offsetRejected_r,
	input wire stur_pkg::stur_offset_t activeOffset_r
);
	logic [2:0]  upCnt_r;
	logic [31:0] gapCnt_r;
	// Cycles since reset release and since the last run
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			upCnt_r  <= 3'h0;
			gapCnt_r <= 32'h0;
		end else begin
			upCnt_r  <= upCnt_r + {2'h0, upCnt_r != 3'h7};
			gapCnt_r <= testDone_r ? 32'h0 : gapCnt_r + 32'h1;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	a_run_period: assert property (
		gapCnt_r <= BIT_PERIOD_CYC + 32'h2) else $error("run overdue");
	a_done_pulse: assert property (
		testDone_r |=> !testDone_r) else $error("done too long");
	a_battery_field: assert property (
		testDone_r |-> resultBattery_r == !$past(batteryVoltageOk))
		else $error("battery field wrong");
	a_params_held: assert property (
		upCnt_r == 3'h7 |-> $stable(resultParams_r))
		else $error("params field moved");
	a_fatal_sticky: assert property (
		resultFatal_r && upCnt_r == 3'h7 |=> resultFatal_r)
		else $error("fatal field cleared");
	a_offset_answer: assert property (
		setOffsetStrobe |=> offsetAccepted_r != offsetRejected_r
		&& offsetAccepted_r == ($past(setOffsetValue) <= `STUR_OFS_MAX
		&& $past(setOffsetValue) >= `STUR_OFS_MIN))
		else $error("offset answer wrong");
	a_no_stray_ack: assert property (
		!setOffsetStrobe && upCnt_r != 3'h0 |=>
		!offsetAccepted_r && !offsetRejected_r) else $error("stray ack");
	a_frac_source: assert property (
		!offsetSourceSelect && upCnt_r != 3'h0 |=>
		activeOffset_r.frac == $past(computedOffsetFrac))
		else $error("computed offset not used");
	a_hours_part: assert property (
		testDone_r |-> activeOffset_r.hours == `STUR_OFS_HOURS)
		else $error("hour part wrong");
	a_tx_hold: assert property (
		txValid_r && !txReady |=> txValid_r && $stable(txItem_r))
		else $error("byte dropped under stall");
	c_accept: cover property (offsetAccepted_r);
	c_reject: cover property (offsetRejected_r);
	c_stall: cover property (txValid_r && !txReady);
endmodule

bind stur_top stur_sva #(.BIT_PERIOD_CYC(BIT_PERIOD_CYC)) u_stur_sva (
	.sys_clk(sys_clk), .rst_n(rst_n), .batteryVoltageOk(batteryVoltageOk),
	.setOffsetStrobe(setOffsetStrobe), .setOffsetValue(setOffsetValue),
	.offsetSourceSelect(offsetSourceSelect), .txReady(txReady),
	.computedOffsetFrac(computedOffsetFrac), .txValid_r(txValid_r),
	.txItem_r(txItem_r), .resultBattery_r(resultBattery_r),
	.resultParams_r(resultParams_r), .resultFatal_r(resultFatal_r),
	.testDone_r(testDone_r), .offsetAccepted_r(offsetAccepted_r),
	.offsetRejected_r(offsetRejected_r), .activeOffset_r(activeOffset_r)
);

// ==== testbench/stur_host_model.sv ====
// Host-side consumer of the framer's byte stream
`timescale 1ns/1ps
module stur_host_model (
	input  wire logic               sys_clk,
	input  wire logic               stallEn,
	input  wire logic               txValid,
	input  wire stur_pkg::stur_tx_t txItem,
	output logic                    txReady,
	output logic                    rxStrobe,
	output stur_pkg::stur_tx_t      rxItem
);
	logic [3:0] phase_r = 4'h0;
	initial txReady = 1'b0;
	// Stall 12 of 16 cycles when asked, so the FIFO fills up
	always @(negedge sys_clk) begin
		phase_r <= phase_r + 4'h1;
		txReady <= !stallEn || (phase_r > 4'hB);
	end
	// Hand each accepted byte over one cycle later
	always @(posedge sys_clk) begin
		rxStrobe <= txValid && txReady;
		rxItem   <= txItem;
	end
endmodule

// ==== testbench/stur_top_test.sv ====
// Self-checking bench for the report framer
`timescale 1ns/1ps
`include "stur_cfg.svh"
module stur_top_test;
	localparam int unsigned PER = 50;
	logic                   sys_clk = 1'b0, rst_n = 1'b0;
	logic                   batteryVoltageOk = 1'b1, fatalResetFlag = 1'b0;
	logic [15:0]            nvParamSum = 16'h5A5A;
	logic                   fatalFault = 1'b0, selfTestQuery = 1'b0;
	logic                   utcOffsetQuery = 1'b0, queryArrivalB = 1'b0;
	stur_pkg::stur_port_t   selfTestPort = stur_pkg::STUR_PORT_NONE;
	stur_pkg::stur_port_t   utcPort = stur_pkg::STUR_PORT_NONE;
	logic                   setOffsetStrobe = 1'b0, offsetSourceSelect = 1'b0;
	logic signed [31:0]     setOffsetValue = 32'sh0, computedOffsetFrac = 32'sh0;
	stur_pkg::stur_iono_t   ionoRecord = '0;
	logic                   txReady, txValid_r, rxStrobe, testDone_r;
	logic                   resultBattery_r, resultParams_r, resultFatal_r;
	logic                   offsetAccepted_r, offsetRejected_r, stallEn = 1'b0;
	stur_pkg::stur_tx_t     txItem_r, rxItem, byteQ[$];
	stur_pkg::stur_offset_t activeOffset_r;
	logic                   ofsQ[$], pb, framerBusy_r;
	logic [7:0]             xr;
	logic signed [31:0]     ofs [5];
	logic [15:0]            nvs [5] = '{16'h5A5A, 16'hA5A5, 16'h1234,
		16'hFEDC, 16'h0BAD};
	stur_pkg::stur_port_t   ports [3] = '{stur_pkg::STUR_PORT_NONE,
		stur_pkg::STUR_PORT_A, stur_pkg::STUR_PORT_B};
	int                     numErrors = 0, comparisons = 0;

	stur_top #(.BIT_PERIOD_CYC(PER)) u_stur_top (.*);
	stur_host_model u_stur_host_model (.sys_clk(sys_clk), .stallEn(stallEn),
		.txValid(txValid_r), .txItem(txItem_r), .txReady(txReady),
		.rxStrobe(rxStrobe), .rxItem(rxItem));

	always #50 sys_clk = ~sys_clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			numErrors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Compared %0d, mismatched %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Expected byte with the running sentence XOR
	task automatic put(input logic [7:0] b);
		byteQ.push_back({pb, b});
		xr = xr ^ b;
	endtask

	task automatic header(input logic [31:0] tag);
		logic [87:0] h;
		h = {`STUR_HDR_PFX, tag};
		xr = h[87:80];
		for (int i = 0; i < 11; i++)
			put(h[87 - 8 * i -: 8]);
	endtask

	function automatic logic [7:0] hexc(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction

	// Self-test sentence; a set flag means that field fails
	task automatic expTest(input logic c1, input logic c2, input logic c3);
		logic [7:0] hc;
		check(32'({resultBattery_r, resultParams_r, resultFatal_r}), 32'({c1, c2, c3}));
		header(`STUR_TAG_TEST);
		put(c1 ? 8'h46 : 8'h50);
		put(8'h2C);
		put(c2 ? 8'h46 : 8'h50);
		put(8'h2C);
		put(c3 ? 8'h46 : 8'h50);
		hc = xr;
		put(8'h2A);
		put(hexc(hc[7:4]));
		put(hexc(hc[3:0]));
		put(8'h0D);
		put(8'h0A);
	endtask

	// Binary reply: six words, their sum, low byte first
	task automatic expUtc(input stur_pkg::stur_iono_t r);
		logic [15:0] w [7];
		w[0] = r.refWeek & 16'h03FF;
		w[1] = r.refTimeSec[27:12];
		w[2] = r.curLeap;
		w[3] = r.changeWeek & 16'h03FF;
		w[4] = (r.changeDay < 16'h0001) ? 16'h0001 :
			(r.changeDay > 16'h0007) ? 16'h0007 : r.changeDay;
		w[5] = r.newLeap;
		w[6] = w[0] + w[1] + w[2] + w[3] + w[4] + w[5];
		header(`STUR_TAG_UTC);
		for (int i = 0; i < 7; i++) begin
			put(w[i][7:0]);
			put(w[i][15:8]);
		end
		put(8'h0D);
		put(8'h0A);
	endtask

	task automatic doReset(input logic bat, input logic [15:0] nv,
		input logic ff);
		@(negedge sys_clk);
		rst_n = 1'b0;
		batteryVoltageOk = bat;
		nvParamSum = nv;
		fatalResetFlag = ff;
		repeat (3) @(negedge sys_clk);
		rst_n = 1'b1;
	endtask

	task automatic waitDone();
		int n;
		n = 0;
		@(negedge sys_clk);
		while (testDone_r !== 1'b1 && n < PER + 3) begin
			@(negedge sys_clk);
			n++;
		end
		check(testDone_r, 32'h1);
	endtask

	task automatic waitIdle();
		int n;
		n = 0;
		while ((byteQ.size() != 0 || framerBusy_r !== 1'b0) && n < 600) begin
			@(negedge sys_clk);
			n++;
		end
		check(byteQ.size(), 32'h0);
	endtask

	task automatic query(input logic utc, input stur_pkg::stur_port_t p,
		input logic arr);
		@(negedge sys_clk);
		selfTestQuery = !utc;
		utcOffsetQuery = utc;
		selfTestPort = p;
		utcPort = p;
		queryArrivalB = arr;
		pb = (p == stur_pkg::STUR_PORT_NONE) ? arr :
			(p == stur_pkg::STUR_PORT_B);
		@(negedge sys_clk);
		selfTestQuery = 1'b0;
		utcOffsetQuery = 1'b0;
		@(negedge sys_clk);
		check(framerBusy_r, 32'h1);
	endtask

	// Compares each accepted byte or offset answer with the oldest note
	always @(posedge sys_clk) begin
		if (rxStrobe === 1'b1)
			check(32'(rxItem), (byteQ.size() != 0) ?
				32'(byteQ.pop_front()) : 32'hFFFFFFFF);
		if (offsetAccepted_r === 1'b1 || offsetRejected_r === 1'b1)
			check(32'(offsetAccepted_r), (ofsQ.size() != 0) ?
				32'(ofsQ.pop_front()) : 32'h2);
	end

	// Main sequence
	initial begin
		void'($urandom(32'h524A3C47));
		for (int i = 0; i < 5; i++) begin
			stallEn = i[1];
			doReset(i[0], nvs[i], i == 2);
			waitDone();
			query(1'b0, ports[i % 3], 1'($urandom));
			expTest(!i[0], i == 4, i == 2);
			waitIdle();
			batteryVoltageOk = !batteryVoltageOk;
			nvParamSum = nvs[(i + 1) % 5];
			fatalFault = (i == 3);
			@(negedge sys_clk);
			fatalFault = 1'b0;
			waitDone();
			query(1'b0, stur_pkg::STUR_PORT_NONE, 1'($urandom));
			expTest(i[0], i == 4, i == 2 || i == 3);
			waitIdle();
			$display("Self-test case %0d done", i);
		end
		stallEn = 1'b1;
		for (int i = 0; i < 3; i++) begin
			ionoRecord = 112'({$urandom, $urandom, $urandom, $urandom});
			ionoRecord.changeDay = 16'(i * 4);
			query(1'b1, ports[i], 1'($urandom));
			expUtc(ionoRecord);
			waitIdle();
			$display("Offset reply case %0d done", i);
		end
		ofs = '{32'sh004C4B40, 32'sh004C4B41, -32'sh004C4B40,
			-32'sh004C4B41, 32'sh0};
		ofs[4] = 32'($urandom_range(32'h00989680)) - 32'sh004C4B40;
		for (int i = 0; i < 5; i++) begin
			@(negedge sys_clk);
			setOffsetStrobe = 1'b1;
			setOffsetValue = ofs[i];
			ofsQ.push_back(!i[0]);
		end
		@(negedge sys_clk);
		setOffsetStrobe = 1'b0;
		computedOffsetFrac = 32'($urandom);
		offsetSourceSelect = 1'b1;
		repeat (3) @(negedge sys_clk);
		check(activeOffset_r.frac, ofs[4]);
		check(32'(activeOffset_r.leapSec), 32'(ionoRecord.curLeap));
		check(32'(activeOffset_r.hours), 32'(`STUR_OFS_HOURS));
		offsetSourceSelect = 1'b0;
		repeat (2) @(negedge sys_clk);
		check(activeOffset_r.frac, computedOffsetFrac);
		check(ofsQ.size(), 32'h0);
		$display("Offset command case done");
		print_verdict();
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		numErrors++;
		print_verdict();
	end
endmodule
